// file: lic_pkg.sv
// shared constants and types for the local interrupt controller addressing
package lic_pkg;
    // legacy register window spans one 4K-byte page
    localparam int MMIO_AW = 12;
    localparam int MSR_IW = 8;
    localparam int NCORES = 4;
    localparam int VEC_W = 8;
    localparam int DM_W = 3;

    localparam logic [MMIO_AW-1:0] OFF_ID = 12'h020;
    localparam logic [MMIO_AW-1:0] OFF_LDR = 12'h0d0;
    localparam logic [MMIO_AW-1:0] OFF_EOI = 12'h0b0;
    localparam logic [MMIO_AW-1:0] OFF_ICR_LO = 12'h300;
    localparam logic [MMIO_AW-1:0] OFF_ICR_HI = 12'h310;

    localparam logic [MSR_IW-1:0] MSR_ID = 8'h02;
    localparam logic [MSR_IW-1:0] MSR_LDR = 8'h0d;
    localparam logic [MSR_IW-1:0] MSR_EOI = 8'h0b;
    localparam logic [MSR_IW-1:0] MSR_ICR = 8'h30;

    localparam int PHYS_LEGACY_W = 8;
    localparam int PHYS_EXT_W = 32;
    localparam int CLUSTER_W = 16;
    localparam int LOGICAL_W = 16;
    localparam int CLUSTER_LSB = 16;

    localparam int ICR_VEC_LSB = 0;
    localparam int ICR_DM_LSB = 8;
    localparam int ICR_LOG_BIT = 11;
    localparam int ICR_DEST_LSB = 32;

    localparam logic [31:0] ID_RESET = 32'h0000_0000;
    localparam logic [31:0] LDR_RESET = 32'h0000_0000;
    localparam logic [7:0] BCAST_LEGACY = 8'hff;
    localparam logic [31:0] BCAST_EXT = 32'hffff_ffff;

    typedef enum logic [0:0] {
        MODE_LEGACY = 1'b0,
        MODE_EXT = 1'b1
    } mode_t;

    typedef enum logic [1:0] {
        CORE_C0 = 2'b00,
        CORE_C1 = 2'b01,
        CORE_DEEP = 2'b10
    } core_state_t;
endpackage

// file: dest_if.sv
// carrier between the controller and its destination matcher
`timescale 1ns/10ps
interface dest_if;
    logic ext;
    logic [31:0] id;
    logic [31:0] ldr;
    logic [31:0] dest;
    logic logical;
    logic hit;
    modport ctrl(output ext, output id, output ldr, output dest,
                 output logical, input hit);
    modport match(input ext, input id, input ldr, input dest,
                  input logical, output hit);
endinterface

// file: dest_match.sv
// destination address match for both addressing modes
`timescale 1ns/10ps
module dest_match
    import lic_pkg::*;
(
    dest_if.match dm
);
    // decoding fewer bits than the field holds stays invisible, since
    // stored identifiers always read back whole
    logic [PHYS_EXT_W-1:0] phys_mask;
    logic [CLUSTER_W-1:0] cl_mask;
    logic [LOGICAL_W-1:0] lg_mask;
    assign phys_mask = {PHYS_EXT_W{1'b1}}; // RQ5
    assign cl_mask = {CLUSTER_W{1'b1}}; // RQ5
    assign lg_mask = {LOGICAL_W{1'b1}}; // RQ5

    always_comb begin
        dm.hit = 1'b0;
        if (!dm.ext) begin
            if (dm.logical) begin
                dm.hit = |(dm.dest[PHYS_LEGACY_W-1:0] &
                           dm.ldr[PHYS_LEGACY_W-1:0]);
            end else begin
                dm.hit = dm.dest[PHYS_LEGACY_W-1:0] == BCAST_LEGACY ||
                         dm.dest[PHYS_LEGACY_W-1:0] ==
                         dm.id[PHYS_LEGACY_W-1:0];
            end
        end else if (dm.logical) begin
            // upper half selects the cluster, lower half is a member mask
            dm.hit = ((dm.dest[CLUSTER_LSB+:CLUSTER_W] ^
                       dm.ldr[CLUSTER_LSB+:CLUSTER_W]) & cl_mask) == '0 &&
                     |(dm.dest[LOGICAL_W-1:0] & dm.ldr[LOGICAL_W-1:0] &
                       lg_mask); // RQ4
        end else begin
            dm.hit = dm.dest == BCAST_EXT ||
                     ((dm.dest ^ dm.id) & phys_mask) == '0; // RQ3
        end
    end
endmodule

// file: lic_addr.sv
// local interrupt controller: access modes, addressing and routing
// Overview of operation
// [RQ1] legacy mode maps registers in one 4K page
// [RQ2] extended mode: register port only, window refused
// [RQ3] extended physical id grows to 32 bits
// [RQ4] extended logical id: cluster plus member mask
// [RQ5] reduced decode width stays invisible to software
// [RQ6] delivery mode and vector pass through unchanged
// [RQ7] software must request extended mode first
// [RQ8] route to active cores, or C1 for speed
// [RQ9] reset starts in legacy mode
`timescale 1ns/10ps
module lic_addr
    import lic_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ext_mode_req,
    output wire mode_t active_mode,
    input wire logic mmio_valid,
    input wire logic mmio_write,
    input wire logic [MMIO_AW-1:0] mmio_addr,
    input wire logic [31:0] mmio_wdata,
    output wire logic mmio_rvalid,
    output wire logic mmio_err,
    output wire logic [31:0] mmio_rdata,
    input wire logic msr_valid,
    input wire logic msr_write,
    input wire logic [MSR_IW-1:0] msr_index,
    input wire logic [63:0] msr_wdata,
    output wire logic msr_rvalid,
    output wire logic msr_err,
    output wire logic [63:0] msr_rdata,
    input wire logic msg_valid,
    input wire logic [31:0] msg_dest,
    input wire logic msg_logical,
    input wire logic [DM_W-1:0] msg_dmode,
    input wire logic [VEC_W-1:0] msg_vector,
    output wire logic msg_accept,
    output wire logic [DM_W-1:0] msg_dmode_out,
    output wire logic [VEC_W-1:0] msg_vector_out,
    output wire logic ipi_valid,
    output wire logic [31:0] ipi_dest,
    output wire logic ipi_logical,
    output wire logic [DM_W-1:0] ipi_dmode,
    output wire logic [VEC_W-1:0] ipi_vector,
    output wire logic eoi_pulse,
    input wire logic route_req,
    input wire logic route_perf,
    input wire core_state_t core_state [NCORES],
    input wire logic [NCORES-1:0] core_loaded,
    output wire logic route_valid,
    output wire logic [NCORES-1:0] route_grant
);
    function automatic logic mmio_known(input logic [MMIO_AW-1:0] a);
        return a == OFF_ID || a == OFF_LDR || a == OFF_EOI ||
               a == OFF_ICR_LO || a == OFF_ICR_HI;
    endfunction

    function automatic logic msr_known(input logic [MSR_IW-1:0] i);
        return i == MSR_ID || i == MSR_LDR || i == MSR_EOI || i == MSR_ICR;
    endfunction

    function automatic logic [NCORES-1:0] first_one(
        input logic [NCORES-1:0] m);
        logic [NCORES-1:0] r;
        r = '0;
        for (int k = NCORES - 1; k >= 0; k--) begin
            if (m[k]) begin
                r = '0;
                r[k] = 1'b1;
            end
        end
        return r;
    endfunction

    mode_t mode_q, mode_d;
    logic [31:0] id_q, id_d, ldr_q, ldr_d;
    logic [31:0] icr_lo_q, icr_lo_d, icr_hi_q, icr_hi_d;
    logic mmio_rvalid_q, mmio_rvalid_d, mmio_err_q, mmio_err_d;
    logic [31:0] mmio_rdata_q, mmio_rdata_d;
    logic msr_rvalid_q, msr_rvalid_d, msr_err_q, msr_err_d;
    logic [63:0] msr_rdata_q, msr_rdata_d;
    logic acc_q, acc_d;
    logic [DM_W-1:0] mdm_q, mdm_d;
    logic [VEC_W-1:0] mvec_q, mvec_d;
    logic ipi_q, ipi_d, ipi_log_q, ipi_log_d, eoi_q, eoi_d;
    logic [31:0] ipi_dest_q, ipi_dest_d;
    logic [DM_W-1:0] ipi_dm_q, ipi_dm_d;
    logic [VEC_W-1:0] ipi_vec_q, ipi_vec_d;
    logic rv_q, rv_d;
    logic [NCORES-1:0] grant_q, grant_d;
    logic [NCORES-1:0] c0_mask, c1_mask, deep_mask, idle_ok;

    dest_if dm();
    dest_match u_match (.dm(dm));

    assign dm.ext = mode_q == MODE_EXT;
    assign dm.id = id_q;
    assign dm.ldr = ldr_q;
    assign dm.dest = msg_dest;
    assign dm.logical = msg_logical;

    always_comb begin
        mode_d = mode_q;
        id_d = id_q;
        ldr_d = ldr_q;
        icr_lo_d = icr_lo_q;
        icr_hi_d = icr_hi_q;
        mmio_rvalid_d = 1'b0;
        mmio_err_d = 1'b0;
        mmio_rdata_d = '0;
        msr_rvalid_d = 1'b0;
        msr_err_d = 1'b0;
        msr_rdata_d = '0;
        ipi_d = 1'b0;
        eoi_d = 1'b0;
        ipi_dest_d = ipi_dest_q;
        ipi_log_d = ipi_log_q;
        ipi_dm_d = ipi_dm_q;
        ipi_vec_d = ipi_vec_q;
        // back to legacy only through reset, so software never sees a
        // half-switched register set
        if (ext_mode_req) begin
            mode_d = MODE_EXT; // RQ7
        end
        if (mmio_valid) begin
            mmio_rvalid_d = 1'b1;
            if (mode_q == MODE_EXT || !mmio_known(mmio_addr)) begin
                mmio_err_d = 1'b1; // RQ2
            end else if (mmio_write) begin
                case (mmio_addr) // RQ1
                    OFF_ID: id_d = 32'(mmio_wdata[PHYS_LEGACY_W-1:0]);
                    OFF_LDR: ldr_d = 32'(mmio_wdata[PHYS_LEGACY_W-1:0]);
                    OFF_EOI: eoi_d = 1'b1;
                    OFF_ICR_HI: icr_hi_d = mmio_wdata;
                    OFF_ICR_LO: begin
                        icr_lo_d = mmio_wdata;
                        ipi_d = 1'b1;
                        ipi_dest_d = 32'(icr_hi_q[PHYS_LEGACY_W-1:0]);
                        ipi_log_d = mmio_wdata[ICR_LOG_BIT];
                        ipi_dm_d = mmio_wdata[ICR_DM_LSB+:DM_W];
                        ipi_vec_d = mmio_wdata[ICR_VEC_LSB+:VEC_W];
                    end
                    default: ;
                endcase
            end else begin
                case (mmio_addr)
                    OFF_ID: mmio_rdata_d = id_q;
                    OFF_LDR: mmio_rdata_d = ldr_q;
                    OFF_ICR_LO: mmio_rdata_d = icr_lo_q;
                    OFF_ICR_HI: mmio_rdata_d = icr_hi_q;
                    default: mmio_rdata_d = '0;
                endcase
            end
        end
        if (msr_valid) begin
            msr_rvalid_d = 1'b1;
            if (mode_q != MODE_EXT || !msr_known(msr_index)) begin
                msr_err_d = 1'b1; // RQ2
            end else if (msr_write) begin
                case (msr_index)
                    MSR_ID: id_d = msr_wdata[31:0]; // RQ3
                    MSR_LDR: ldr_d = msr_wdata[31:0]; // RQ4
                    MSR_EOI: eoi_d = 1'b1;
                    MSR_ICR: begin
                        // one write carries the whole command and sends it
                        icr_lo_d = msr_wdata[31:0];
                        icr_hi_d = msr_wdata[63:32];
                        ipi_d = 1'b1;
                        ipi_dest_d = msr_wdata[ICR_DEST_LSB+:32]; // RQ3
                        ipi_log_d = msr_wdata[ICR_LOG_BIT];
                        ipi_dm_d = msr_wdata[ICR_DM_LSB+:DM_W];
                        ipi_vec_d = msr_wdata[ICR_VEC_LSB+:VEC_W];
                    end
                    default: ;
                endcase
            end else begin
                case (msr_index)
                    MSR_ID: msr_rdata_d = 64'(id_q);
                    MSR_LDR: msr_rdata_d = 64'(ldr_q);
                    MSR_ICR: msr_rdata_d = {icr_hi_q, icr_lo_q};
                    default: msr_rdata_d = '0;
                endcase
            end
        end
        acc_d = msg_valid && dm.hit;
        mdm_d = msg_valid ? msg_dmode : mdm_q; // RQ6
        mvec_d = msg_valid ? msg_vector : mvec_q; // RQ6
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mode_q <= MODE_LEGACY; // RQ9
            id_q <= ID_RESET;
            ldr_q <= LDR_RESET;
            icr_lo_q <= '0;
            icr_hi_q <= '0;
            mmio_rvalid_q <= 1'b0;
            mmio_err_q <= 1'b0;
            mmio_rdata_q <= '0;
            msr_rvalid_q <= 1'b0;
            msr_err_q <= 1'b0;
            msr_rdata_q <= '0;
            acc_q <= 1'b0;
            mdm_q <= '0;
            mvec_q <= '0;
            ipi_q <= 1'b0;
            eoi_q <= 1'b0;
            ipi_dest_q <= '0;
            ipi_log_q <= 1'b0;
            ipi_dm_q <= '0;
            ipi_vec_q <= '0;
        end else begin
            mode_q <= mode_d;
            id_q <= id_d;
            ldr_q <= ldr_d;
            icr_lo_q <= icr_lo_d;
            icr_hi_q <= icr_hi_d;
            mmio_rvalid_q <= mmio_rvalid_d;
            mmio_err_q <= mmio_err_d;
            mmio_rdata_q <= mmio_rdata_d;
            msr_rvalid_q <= msr_rvalid_d;
            msr_err_q <= msr_err_d;
            msr_rdata_q <= msr_rdata_d;
            acc_q <= acc_d;
            mdm_q <= mdm_d;
            mvec_q <= mvec_d;
            ipi_q <= ipi_d;
            eoi_q <= eoi_d;
            ipi_dest_q <= ipi_dest_d;
            ipi_log_q <= ipi_log_d;
            ipi_dm_q <= ipi_dm_d;
            ipi_vec_q <= ipi_vec_d;
        end
    end

    for (genvar g = 0; g < NCORES; g++) begin : g_state
        assign c0_mask[g] = core_state[g] == CORE_C0;
        assign c1_mask[g] = core_state[g] == CORE_C1;
        assign deep_mask[g] = core_state[g] == CORE_DEEP;
        assign idle_ok[g] = c0_mask[g] && !core_loaded[g];
    end

    // deep idle cores are only a last resort, when nothing else is awake
    always_comb begin
        rv_d = route_req;
        grant_d = '0;
        if (route_req) begin
            if (route_perf && |c1_mask) begin
                grant_d = first_one(c1_mask); // RQ8
            end else if (route_perf && |idle_ok) begin
                grant_d = first_one(idle_ok); // RQ8
            end else if (|c0_mask) begin
                grant_d = first_one(c0_mask); // RQ8
            end else if (|c1_mask) begin
                grant_d = first_one(c1_mask); // RQ8
            end else begin
                grant_d = first_one(deep_mask);
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rv_q <= 1'b0;
            grant_q <= '0;
        end else begin
            rv_q <= rv_d;
            grant_q <= grant_d;
        end
    end

    assign active_mode = mode_q;
    assign mmio_rvalid = mmio_rvalid_q;
    assign mmio_err = mmio_err_q;
    assign mmio_rdata = mmio_rdata_q;
    assign msr_rvalid = msr_rvalid_q;
    assign msr_err = msr_err_q;
    assign msr_rdata = msr_rdata_q;
    assign msg_accept = acc_q;
    assign msg_dmode_out = mdm_q;
    assign msg_vector_out = mvec_q;
    assign ipi_valid = ipi_q;
    assign ipi_dest = ipi_dest_q;
    assign ipi_logical = ipi_log_q;
    assign ipi_dmode = ipi_dm_q;
    assign ipi_vector = ipi_vec_q;
    assign eoi_pulse = eoi_q;
    assign route_valid = rv_q;
    assign route_grant = grant_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_ext_id_wr;
        msr_valid && msr_write && mode_q == MODE_EXT && msr_index == MSR_ID;
    endsequence
    sequence s_leg_id_wr;
        mmio_valid && mmio_write && mode_q == MODE_LEGACY &&
        mmio_addr == OFF_ID;
    endsequence

    a_mode_stays_legacy: assert property ( // RQ9
        mode_q == MODE_LEGACY && !ext_mode_req |=> mode_q == MODE_LEGACY)
        else $error("mode left legacy without a request");
    a_mode_sticky: assert property ( // RQ7
        ext_mode_req |=> mode_q == MODE_EXT [*2])
        else $error("extended mode not held after request");
    a_window_refused: assert property ( // RQ2
        mmio_valid && mode_q == MODE_EXT |=> mmio_rvalid && mmio_err)
        else $error("window access not refused in extended mode");
    a_window_legacy: assert property ( // RQ1
        mmio_valid && mode_q == MODE_LEGACY && mmio_known(mmio_addr)
        |=> mmio_rvalid && !mmio_err)
        else $error("legacy window access refused");
    a_port_ext: assert property ( // RQ2
        msr_valid && mode_q == MODE_EXT && msr_known(msr_index)
        |=> msr_rvalid && !msr_err)
        else $error("register port access refused in extended mode");
    a_id_wide: assert property ( // RQ3
        s_ext_id_wr |=> id_q == $past(msr_wdata[31:0]))
        else $error("extended id not stored in full");
    a_id_narrow: assert property ( // RQ3
        s_leg_id_wr |=> id_q[31:PHYS_LEGACY_W] == '0)
        else $error("legacy id wider than eight bits");
    a_cluster_miss: assert property ( // RQ4
        msg_valid && mode_q == MODE_EXT && msg_logical &&
        msg_dest[CLUSTER_LSB+:CLUSTER_W] != ldr_q[CLUSTER_LSB+:CLUSTER_W]
        |=> !msg_accept)
        else $error("message accepted for a foreign cluster");
    a_dmode_kept: assert property ( // RQ6
        msg_valid |=> msg_dmode_out == $past(msg_dmode) &&
        msg_vector_out == $past(msg_vector))
        else $error("delivery mode or vector altered");
    a_route_energy: assert property ( // RQ8
        route_req && !route_perf && |c0_mask
        |=> route_valid && (route_grant & ~$past(c0_mask)) == '0 &&
        $onehot(route_grant))
        else $error("energy routing chose a sleeping core");
    a_route_perf: assert property ( // RQ8
        route_req && route_perf && |c1_mask
        |=> (route_grant & ~$past(c1_mask)) == '0 && $onehot(route_grant))
        else $error("performance routing skipped a C1 core");
endmodule

// file: lic_partner.sv
// far-side model: interrupt sources and core power states
`timescale 1ns/10ps
module lic_partner
    import lic_pkg::*;
(
    input wire logic mclk,
    output logic msg_valid,
    output logic [31:0] msg_dest,
    output logic msg_logical,
    output logic [DM_W-1:0] msg_dmode,
    output logic [VEC_W-1:0] msg_vector,
    output logic route_req,
    output logic route_perf,
    output core_state_t core_state [NCORES],
    output logic [NCORES-1:0] core_loaded
);
    initial begin
        msg_valid = 1'b0;
        msg_dest = 32'h0000_0000;
        msg_logical = 1'b0;
        msg_dmode = 3'h0;
        msg_vector = 8'h00;
        route_req = 1'b0;
        route_perf = 1'b0;
        core_loaded = 4'h0;
        for (int i = 0; i < NCORES; i++) begin
            core_state[i] = CORE_DEEP;
        end
    end

    task automatic send(input logic [31:0] d, input logic lg,
                        input logic [DM_W-1:0] m, input logic [VEC_W-1:0] v);
        @(posedge mclk);
        #1;
        msg_valid = 1'b1;
        msg_dest = d;
        msg_logical = lg;
        msg_dmode = m;
        msg_vector = v;
        @(posedge mclk);
        #1;
        msg_valid = 1'b0;
        // released fields turn to junk so a late sampler cannot pass
        msg_dest = ~d;
        msg_logical = ~lg;
        msg_dmode = ~m;
        msg_vector = ~v;
    endtask

    task automatic route(input logic pf, input logic [7:0] st,
                         input logic [NCORES-1:0] ld);
        @(posedge mclk);
        #1;
        route_req = 1'b1;
        route_perf = pf;
        core_loaded = ld;
        for (int i = 0; i < NCORES; i++) begin
            core_state[i] = core_state_t'(st[2*i+:2]);
        end
        @(posedge mclk);
        #1;
        route_req = 1'b0;
    endtask
endmodule

// file: local_interrupt_ctrl_addressing_tb_top.sv
// self-checking bench for access modes, addressing and routing
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module local_interrupt_ctrl_addressing_tb_top
    import lic_pkg::*;
();
    logic mclk, rst, ext_mode_req;
    mode_t active_mode;
    logic mmio_valid, mmio_write, mmio_rvalid, mmio_err;
    logic [MMIO_AW-1:0] mmio_addr;
    logic [31:0] mmio_wdata, mmio_rdata;
    logic msr_valid, msr_write, msr_rvalid, msr_err;
    logic [MSR_IW-1:0] msr_index;
    logic [63:0] msr_wdata, msr_rdata;
    logic msg_valid, msg_logical, msg_accept;
    logic [31:0] msg_dest, ipi_dest;
    logic [DM_W-1:0] msg_dmode, msg_dmode_out, ipi_dmode;
    logic [VEC_W-1:0] msg_vector, msg_vector_out, ipi_vector;
    logic ipi_valid, ipi_logical, eoi_pulse;
    logic route_req, route_perf, route_valid;
    core_state_t core_state [NCORES];
    logic [NCORES-1:0] core_loaded, route_grant;
    int err_total = 0;
    int check_count = 0;

    lic_addr dut (.mclk, .rst, .ext_mode_req, .active_mode, .mmio_valid,
        .mmio_write, .mmio_addr, .mmio_wdata, .mmio_rvalid, .mmio_err,
        .mmio_rdata, .msr_valid, .msr_write, .msr_index, .msr_wdata,
        .msr_rvalid, .msr_err, .msr_rdata, .msg_valid, .msg_dest,
        .msg_logical, .msg_dmode, .msg_vector, .msg_accept, .msg_dmode_out,
        .msg_vector_out, .ipi_valid, .ipi_dest, .ipi_logical, .ipi_dmode,
        .ipi_vector, .eoi_pulse, .route_req, .route_perf, .core_state,
        .core_loaded, .route_valid, .route_grant);
    lic_partner peer (.mclk, .msg_valid, .msg_dest, .msg_logical,
        .msg_dmode, .msg_vector, .route_req, .route_perf, .core_state,
        .core_loaded);

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic mm(input logic w, input logic [MMIO_AW-1:0] a,
                      input logic [31:0] d, input logic [31:0] xr,
                      input logic xe);
        @(posedge mclk);
        #1;
        mmio_valid = 1'b1;
        mmio_write = w;
        mmio_addr = a;
        mmio_wdata = d;
        @(posedge mclk);
        #1;
        mmio_valid = 1'b0;
        mmio_wdata = ~d;
        `CHK(mmio_rvalid, 1'b1)
        `CHK(mmio_err, xe)
        if (!xe) `CHK(mmio_rdata, xr)
    endtask

    task automatic ms(input logic w, input logic [MSR_IW-1:0] a,
                      input logic [63:0] d, input logic [63:0] xr,
                      input logic xe);
        @(posedge mclk);
        #1;
        msr_valid = 1'b1;
        msr_write = w;
        msr_index = a;
        msr_wdata = d;
        @(posedge mclk);
        #1;
        msr_valid = 1'b0;
        msr_wdata = ~d;
        `CHK(msr_rvalid, 1'b1)
        `CHK(msr_err, xe)
        if (!xe) `CHK(msr_rdata, xr)
    endtask

    // message fields derive from dest so each accept checks the copy
    task automatic mg(input logic [31:0] d, input logic lg, input logic xa);
        peer.send(d, lg, d[2:0], d[7:0] ^ 8'h5a);
        `CHK(msg_accept, xa)
        if (xa) `CHK({msg_dmode_out, msg_vector_out}, {d[2:0], d[7:0] ^ 8'h5a})
    endtask

    task automatic rt(input logic pf, input logic [7:0] st,
                      input logic [3:0] ld, input logic [3:0] xg);
        peer.route(pf, st, ld);
        `CHK(route_valid, 1'b1)
        `CHK(route_grant, xg)
    endtask

    task automatic t_reset();
        `CHK(active_mode, MODE_LEGACY)
        mm(1'b0, OFF_ID, 32'h0000_0000, ID_RESET, 1'b0);
        ms(1'b0, MSR_ID, 64'h0, 64'h0, 1'b1);
        $display("reset test done");
    endtask

    task automatic t_legacy();
        mm(1'b1, OFF_ID, 32'h1234_5678, 32'h0000_0000, 1'b0);
        mm(1'b0, OFF_ID, 32'h0000_0000, 32'h0000_0078, 1'b0);
        ms(1'b1, MSR_ID, 64'h0000_0000_0000_0099, 64'h0, 1'b1);
        mm(1'b0, OFF_ID, 32'h0000_0000, 32'h0000_0078, 1'b0);
        mm(1'b1, OFF_LDR, 32'h0000_00f0, 32'h0000_0000, 1'b0);
        mm(1'b0, 12'h3f0, 32'h0000_0000, 32'h0000_0000, 1'b1);
        mm(1'b1, OFF_ICR_HI, 32'h0000_0055, 32'h0000_0000, 1'b0);
        `CHK(ipi_valid, 1'b0)
        mm(1'b1, OFF_ICR_LO, 32'h0000_0441, 32'h0000_0000, 1'b0);
        `CHK(ipi_valid, 1'b1)
        `CHK({ipi_dest, ipi_logical}, {32'h0000_0055, 1'b0})
        `CHK({ipi_dmode, ipi_vector}, {3'h4, 8'h41})
        mm(1'b1, OFF_EOI, 32'h0000_0000, 32'h0000_0000, 1'b0);
        `CHK(eoi_pulse, 1'b1)
        mg(32'h0000_0078, 1'b0, 1'b1);
        mg(32'h0000_0178, 1'b0, 1'b1);
        mg(32'h0000_0079, 1'b0, 1'b0);
        mg(32'h0000_00ff, 1'b0, 1'b1);
        mg(32'h0000_0010, 1'b1, 1'b1);
        mg(32'h0000_000f, 1'b1, 1'b0);
        $display("legacy test done");
    endtask

    task automatic t_ext();
        @(posedge mclk);
        #1;
        ext_mode_req = 1'b1;
        @(posedge mclk);
        #1;
        ext_mode_req = 1'b0;
        @(posedge mclk);
        #1;
        `CHK(active_mode, MODE_EXT)
        ms(1'b1, MSR_ID, 64'h0000_0000_a5c3_1234, 64'h0, 1'b0);
        mm(1'b1, OFF_ID, 32'h0000_0099, 32'h0000_0000, 1'b1);
        mm(1'b0, OFF_ID, 32'h0000_0000, 32'h0000_0000, 1'b1);
        ms(1'b0, MSR_ID, 64'h0, 64'h0000_0000_a5c3_1234, 1'b0);
        ms(1'b1, MSR_LDR, 64'h0000_0000_0003_0024, 64'h0, 1'b0);
        ms(1'b1, MSR_ICR, 64'h8765_4321_0000_0a30, 64'h0, 1'b0);
        `CHK(ipi_valid, 1'b1)
        `CHK({ipi_dest, ipi_logical}, {32'h8765_4321, 1'b1})
        `CHK({ipi_dmode, ipi_vector}, {3'h2, 8'h30})
        ms(1'b0, MSR_ICR, 64'h0, 64'h8765_4321_0000_0a30, 1'b0);
        ms(1'b1, MSR_EOI, 64'h0, 64'h0, 1'b0);
        `CHK(eoi_pulse, 1'b1)
        `CHK(active_mode, MODE_EXT)
        mg(32'ha5c3_1234, 1'b0, 1'b1);
        mg(32'h0000_0034, 1'b0, 1'b0);
        mg(32'hffff_ffff, 1'b0, 1'b1);
        mg(32'h0003_0004, 1'b1, 1'b1);
        mg(32'h0003_0040, 1'b1, 1'b0);
        mg(32'h0004_0004, 1'b1, 1'b0);
        $display("extended test done");
    endtask

    task automatic t_route();
        rt(1'b0, 8'h06, 4'h0, 4'h4);
        rt(1'b1, 8'h06, 4'h0, 4'h2);
        rt(1'b1, 8'h82, 4'h2, 4'h4);
        rt(1'b0, 8'h82, 4'h2, 4'h2);
        rt(1'b1, 8'h00, 4'h7, 4'h8);
        rt(1'b1, 8'h00, 4'hf, 4'h1);
        rt(1'b1, 8'h40, 4'h0, 4'h8);
        rt(1'b0, 8'h40, 4'h0, 4'h1);
        rt(1'b0, 8'h6a, 4'h0, 4'h8);
        rt(1'b1, 8'haa, 4'h0, 4'h1);
        $display("routing test done");
    endtask

    initial begin
        rst = 1'b1;
        ext_mode_req = 1'b0;
        mmio_valid = 1'b0;
        mmio_write = 1'b0;
        mmio_addr = 12'h000;
        mmio_wdata = 32'h0000_0000;
        msr_valid = 1'b0;
        msr_write = 1'b0;
        msr_index = 8'h00;
        msr_wdata = 64'h0;
        repeat (10) @(posedge mclk);
        #1;
        rst = 1'b0;
        t_reset();
        t_legacy();
        t_ext();
        t_route();
        complete_run();
    end

    // about 95 cycles of traffic; the limit at 2500 cycles means a hang
    initial begin
        #10000;
        err_total++;
        complete_run();
    end
endmodule
